// >>> hdl/flash_cfg.svh
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

`define AXI_AW 32
`define AXI_DW 32
`define ARR_AW 16
`define ARR_SEL_BIT 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STRB_LO 4'h3
`define STRB_HI 4'hC
`define INVALID_DATA 32'hFFFFFFFF

`define OFF_CLKDIV 8'h00
`define OFF_CONFIG 8'h04
`define OFF_PROT 8'h08
`define OFF_SEC 8'h0C
`define OFF_STATUS 8'h10
`define OFF_CMD 8'h14

`define ST_BUFFER_EMPTY_FLAG 7
`define ST_COMMAND_COMPLETE_FLAG 6
`define ST_PROTECTION_VIOLATION_FLAG 5
`define ST_ACCESS_ERROR_FLAG 4
`define CFG_BUFFER_EMPTY_IRQ_ENABLE 7
`define CFG_COMMAND_COMPLETE_IRQ_ENABLE 6
`define DIV_DONE 7
`define CFG_RST 8'h00
`define DIV_RST 8'h00
`define PROT_RST 8'hFF
`define SEC_RST 8'h00

`define CMD_VERIFY 8'h05
`define CMD_PROGRAM 8'h20
`define CMD_SECTOR_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41

`define SECTOR_LSB 10
`define SECTOR_W 6
`define SECTOR_CNT 7'h40
`define PROT_LOAD_ADDR 16'hFF0C
`define SEC_LOAD_ADDR 16'hFF0E
`define SEC_UNSECURED 2'h2

`endif

// >>> hdl/flash_pkg.sv
`include "flash_cfg.svh"

package flash_pkg;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h1,
        SEQ_WORD = 4'h2,
        SEQ_CMD = 4'h4,
        SEQ_LAUNCH = 4'h8
    } seq_e;

    typedef enum logic [2:0] {
        CTRL_PROT = 3'h1,
        CTRL_SEC = 3'h2,
        CTRL_RUN = 3'h4
    } ctrl_e;

    typedef struct packed {
        logic [7:0] code;
        logic [`ARR_AW-1:0] addr;
        logic [15:0] data;
    } cmd_s;

endpackage : flash_pkg

// >>> hdl/cmd_pipe.sv
`timescale 1ns/1ps
`default_nettype none

module cmd_pipe
    import flash_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Launch side
    input wire logic push,
    input wire cmd_s push_cmd,
    input wire logic abort,
    // Array core side
    input wire logic done,
    output logic start,
    output cmd_s act_cmd,
    // State
    output logic pend_valid,
    output logic act_valid
);
    cmd_s pend_reg;
    logic take;

    // Buffered command moves on once the core is free
    assign take = pend_valid && (!act_valid || done);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_valid <= 1'b0;
            act_valid <= 1'b0;
            start <= 1'b0;
            pend_reg <= '0;
            act_cmd <= '0;
        end else begin
            start <= take && !abort;
            if (abort) begin
                pend_valid <= 1'b0;
                act_valid <= 1'b0;
            end else begin
                if (take) begin
                    act_cmd <= pend_reg;
                    act_valid <= 1'b1;
                end else if (done) begin
                    act_valid <= 1'b0;
                end
                if (push) begin
                    pend_reg <= push_cmd;
                    pend_valid <= 1'b1;
                end else if (take) begin
                    pend_valid <= 1'b0;
                end
            end
        end
    end

endmodule : cmd_pipe

`default_nettype wire

// >>> hdl/flash_command_error_checker.sv
`timescale 1ns/1ps
`default_nettype none

`include "flash_cfg.svh"

module flash_command_error_checker
    import flash_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // AXI4-Lite write address and data
    input wire logic [`AXI_AW-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [`AXI_DW-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [`AXI_AW-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [`AXI_DW-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // System
    input wire logic STOP_REQ,
    input wire logic BDM_ACTIVE,
    input wire logic CPU_I_MASK,
    output logic CPU_STALL,
    output logic IRQ_REQ,
    // Array read port, asynchronous read
    output logic [`ARR_AW-1:0] ARR_RD_ADDR,
    input wire logic [15:0] ARR_RD_DATA,
    // Array operation core
    output logic OP_START,
    output cmd_s OP_CMD,
    output logic OP_ABORT,
    output logic [6:0] OP_CLK_DIV,
    input wire logic OP_DONE
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ctrl_e ctrl_reg;
    seq_e seq_reg, seq_next;
    logic [7:0] flash_clock_divider_reg;
    logic [7:0] flash_config_reg;
    logic [7:0] flash_protection_reg;
    logic [7:0] flash_security_reg;
    logic access_error_flag, access_error_next;
    logic protection_violation_flag, protection_violation_next;
    logic [7:0] flash_command_reg;
    logic [`ARR_AW-1:0] seq_addr_reg;
    logic [15:0] seq_data_reg;
    logic stop_q_reg;
    logic rd_busy_reg;
    logic rd_lane_reg;
    logic irq_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [`AXI_DW-1:0] rdata_reg;

    logic pend_valid, act_valid;
    logic buffer_empty_flag, command_complete_flag;
    cmd_s push_cmd;

    wire run = (ctrl_reg == CTRL_RUN);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Address and data are taken together; the register file has no
    // write queue, so one outstanding write is the limit.
    wire wr_ev = run && AWVALID && WVALID && !bvalid_reg;
    wire rd_ev = run && ARVALID && !rvalid_reg && !rd_busy_reg;

    assign AWREADY = wr_ev;
    assign WREADY = wr_ev;
    assign ARREADY = rd_ev;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign RVALID = rvalid_reg;
    assign RRESP = rresp_reg;
    assign RDATA = rdata_reg;
    assign CPU_STALL = !run;
    assign IRQ_REQ = irq_reg;
    assign OP_CLK_DIV = flash_clock_divider_reg[6:0];

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire arr_hit = AWADDR[`ARR_SEL_BIT];
    wire [7:0] w_off = AWADDR[7:0];
    wire w_page_zero = !arr_hit && (AWADDR[`AXI_AW-1:8] == '0);
    wire w_div = w_page_zero && (w_off == `OFF_CLKDIV);
    wire w_cfg = w_page_zero && (w_off == `OFF_CONFIG);
    wire w_prot = w_page_zero && (w_off == `OFF_PROT);
    wire w_sec = w_page_zero && (w_off == `OFF_SEC);
    wire w_stat = w_page_zero && (w_off == `OFF_STATUS);
    wire w_cmd = w_page_zero && (w_off == `OFF_CMD);
    wire w_reg = w_div || w_cfg || w_prot || w_sec || w_stat || w_cmd;

    wire wr_arr = wr_ev && arr_hit;
    wire wr_cmd = wr_ev && w_cmd;
    wire wr_stat = wr_ev && w_stat;
    wire wr_any_reg = wr_ev && w_reg;
    wire [7:0] wbyte = WDATA[7:0];

    wire [3:0] exp_strb = AWADDR[1] ? `STRB_HI : `STRB_LO;
    wire [15:0] lane_data = AWADDR[1] ? WDATA[31:16] : WDATA[15:0];
    wire hw_ok = !AWADDR[0] && (WSTRB == exp_strb);

    wire code_valid = (wbyte == `CMD_VERIFY) || (wbyte == `CMD_PROGRAM)
        || (wbyte == `CMD_SECTOR_ERASE) || (wbyte == `CMD_MASS_ERASE);
    wire code_prog_erase = (wbyte == `CMD_PROGRAM) || (wbyte == `CMD_SECTOR_ERASE);
    wire code_mass = (wbyte == `CMD_MASS_ERASE);

    // ------------------------------------------------------------
    // Protection window
    // ------------------------------------------------------------
    // Low nibble protects sectors from the bottom, high nibble from the top.
    wire [3:0] prot_low = flash_protection_reg[3:0];
    wire [3:0] prot_high = flash_protection_reg[7:4];
    wire [`SECTOR_W-1:0] sect = seq_addr_reg[`ARR_AW-1:`SECTOR_LSB];
    wire [6:0] high_base = `SECTOR_CNT - {3'h0, prot_high};
    wire prot_hit = ({2'h0, prot_low} > sect)
        || ((prot_high != 4'h0) && ({1'b0, sect} >= high_base));
    wire any_prot = (prot_low != 4'h0) || (prot_high != 4'h0);
    wire secured = (flash_security_reg[1:0] != `SEC_UNSECURED);
    wire untrusted = AWPROT[1] || BDM_ACTIVE;

    // ------------------------------------------------------------
    // Illegal operation checks
    // ------------------------------------------------------------
    wire in_idle = (seq_reg == SEQ_IDLE);
    wire in_word = (seq_reg == SEQ_WORD);
    wire in_cmd = (seq_reg == SEQ_CMD);
    wire stop_rise = STOP_REQ && !stop_q_reg;

    wire e_clk = wr_arr && !flash_clock_divider_reg[`DIV_DONE];
    wire e_align = wr_arr && !hw_ok;
    wire e_cbe = wr_arr && !buffer_empty_flag;
    wire e_word2 = wr_arr && !in_idle;
    wire e_after_word = wr_any_reg && !w_cmd && in_word;
    wire e_cmd2 = wr_cmd && in_cmd;
    wire e_cmd_early = wr_cmd && in_idle;
    wire e_badcmd = wr_cmd && in_word && !code_valid;
    wire e_secure = wr_cmd && in_word && secured && !code_mass && untrusted;
    wire e_after_cmd = wr_any_reg && !w_stat && in_cmd;
    wire e_cbe0 = wr_stat && !wbyte[`ST_BUFFER_EMPTY_FLAG] && !in_idle;
    wire e_stop = stop_rise && (act_valid || pend_valid);

    wire acc_set = e_clk || e_align || e_cbe || e_word2 || e_after_word
        || e_cmd2 || e_cmd_early || e_badcmd || e_secure || e_after_cmd
        || e_cbe0 || e_stop;

    wire cmd_ok = wr_cmd && in_word && code_valid && !e_secure;
    wire pv_set = cmd_ok && ((code_prog_erase && prot_hit)
        || (code_mass && any_prot));

    wire locked = access_error_flag || protection_violation_flag;
    wire launch = wr_stat && wbyte[`ST_BUFFER_EMPTY_FLAG] && in_cmd && !locked && !e_stop;

    // ------------------------------------------------------------
    // Sequence tracker
    // ------------------------------------------------------------
    always_comb begin
        seq_next = seq_reg;
        unique case (seq_reg)
            SEQ_IDLE: begin
                if (wr_arr && !acc_set) begin
                    seq_next = SEQ_WORD;
                end
            end
            SEQ_WORD: begin
                if (cmd_ok && !pv_set) begin
                    seq_next = SEQ_CMD;
                end
            end
            SEQ_CMD: begin
                if (launch) begin
                    seq_next = SEQ_LAUNCH;
                end
            end
            SEQ_LAUNCH: begin
                seq_next = SEQ_IDLE;
            end
            default: begin
                seq_next = SEQ_IDLE;
            end
        endcase
        if (acc_set || pv_set) begin
            seq_next = SEQ_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    // Hardware set beats a same-cycle write-one clear.
    always_comb begin
        access_error_next = access_error_flag;
        protection_violation_next = protection_violation_flag;
        if (wr_stat && wbyte[`ST_ACCESS_ERROR_FLAG]) begin
            access_error_next = 1'b0;
        end
        if (wr_stat && wbyte[`ST_PROTECTION_VIOLATION_FLAG]) begin
            protection_violation_next = 1'b0;
        end
        if (acc_set) begin
            access_error_next = 1'b1;
        end
        if (pv_set) begin
            protection_violation_next = 1'b1;
        end
    end

    assign buffer_empty_flag = !pend_valid && (seq_reg != SEQ_LAUNCH);
    assign command_complete_flag = !act_valid && !pend_valid && (seq_reg != SEQ_LAUNCH);

    wire [7:0] status_byte = {buffer_empty_flag, command_complete_flag,
        protection_violation_flag, access_error_flag, 4'h0};

    // Sector erase works on whole sectors; low address bits and data are dropped.
    always_comb begin
        push_cmd.code = flash_command_reg;
        push_cmd.addr = seq_addr_reg;
        push_cmd.data = seq_data_reg;
        if (flash_command_reg == `CMD_SECTOR_ERASE) begin
            push_cmd.addr = {sect, {`SECTOR_LSB{1'b0}}};
            push_cmd.data = 16'h0000;
        end
    end

    cmd_pipe u_pipe (
        .clk(CLK),
        .rst_b(RST_B),
        .push(seq_reg == SEQ_LAUNCH),
        .push_cmd(push_cmd),
        .abort(e_stop),
        .done(OP_DONE),
        .start(OP_START),
        .act_cmd(OP_CMD),
        .pend_valid(pend_valid),
        .act_valid(act_valid)
    );

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    wire r_arr = ARADDR[`ARR_SEL_BIT];
    wire r_page_zero = !r_arr && (ARADDR[`AXI_AW-1:8] == '0);
    wire [7:0] r_off = ARADDR[7:0];
    logic [7:0] r_byte;
    logic r_hit;

    always_comb begin
        r_hit = r_page_zero;
        r_byte = 8'h00;
        unique case (r_off)
            `OFF_CLKDIV: r_byte = flash_clock_divider_reg;
            `OFF_CONFIG: r_byte = flash_config_reg;
            `OFF_PROT: r_byte = flash_protection_reg;
            `OFF_SEC: r_byte = flash_security_reg;
            `OFF_STATUS: r_byte = status_byte;
            `OFF_CMD: r_byte = flash_command_reg;
            default: r_hit = 1'b0;
        endcase
    end

    // Invalid data while the array is busy, but no error flag.
    wire [`AXI_DW-1:0] arr_word = rd_lane_reg ? {ARR_RD_DATA, 16'h0000}
        : {16'h0000, ARR_RD_DATA};
    wire [`AXI_DW-1:0] arr_rdata = command_complete_flag ? arr_word : `INVALID_DATA;

    // ------------------------------------------------------------
    // Reset-time load and bus responses
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg <= CTRL_PROT;
            ARR_RD_ADDR <= `PROT_LOAD_ADDR;
            flash_protection_reg <= `PROT_RST;
            flash_security_reg <= `SEC_RST;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= '0;
            rd_busy_reg <= 1'b0;
            rd_lane_reg <= 1'b0;
        end else begin
            unique case (ctrl_reg)
                CTRL_PROT: begin
                    flash_protection_reg <= ARR_RD_DATA[7:0];
                    ARR_RD_ADDR <= `SEC_LOAD_ADDR;
                    ctrl_reg <= CTRL_SEC;
                end
                CTRL_SEC: begin
                    flash_security_reg <= ARR_RD_DATA[7:0];
                    ctrl_reg <= CTRL_RUN;
                end
                CTRL_RUN: begin
                    if (rd_ev && r_arr) begin
                        ARR_RD_ADDR <= ARADDR[`ARR_AW-1:0];
                    end
                end
                default: begin
                    ctrl_reg <= CTRL_PROT;
                end
            endcase
            if (wr_ev) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (arr_hit || w_reg) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (BREADY) begin
                bvalid_reg <= 1'b0;
            end
            rd_busy_reg <= rd_ev && r_arr;
            if (rd_ev) begin
                rd_lane_reg <= ARADDR[1];
            end
            if (rd_ev && !r_arr) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
                rdata_reg <= {24'h000000, r_byte};
            end else if (rd_busy_reg) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= `RESP_OKAY;
                rdata_reg <= arr_rdata;
            end else if (RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Command sequence registers
    // ------------------------------------------------------------
    // Asynchronous reset clears the sequence and the launcher at once.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            seq_reg <= SEQ_IDLE;
            access_error_flag <= 1'b0;
            protection_violation_flag <= 1'b0;
            flash_clock_divider_reg <= `DIV_RST;
            flash_config_reg <= `CFG_RST;
            flash_command_reg <= 8'h00;
            seq_addr_reg <= '0;
            seq_data_reg <= 16'h0000;
            stop_q_reg <= 1'b0;
            OP_ABORT <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            access_error_flag <= access_error_next;
            protection_violation_flag <= protection_violation_next;
            stop_q_reg <= STOP_REQ;
            OP_ABORT <= e_stop;
            if (wr_ev && w_div && in_idle) begin
                flash_clock_divider_reg <= {1'b1, wbyte[6:0]};
            end
            if (wr_ev && w_cfg && in_idle) begin
                flash_config_reg <= {wbyte[7:6], 6'h00};
            end
            if (wr_arr && in_idle && !acc_set) begin
                seq_addr_reg <= AWADDR[`ARR_AW-1:0];
                seq_data_reg <= lane_data;
            end
            if (cmd_ok) begin
                flash_command_reg <= wbyte;
            end
            irq_reg <= !CPU_I_MASK
                && ((buffer_empty_flag && flash_config_reg[`CFG_BUFFER_EMPTY_IRQ_ENABLE])
                || (command_complete_flag && flash_config_reg[`CFG_COMMAND_COMPLETE_IRQ_ENABLE]));
        end
    end

    wire unused_ok = &{1'b0, ARPROT, AWPROT[2], AWPROT[0]};

endmodule : flash_command_error_checker

`default_nettype wire

// >>> sim/array_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module array_core_model
    import flash_pkg::*;
(
    // Bench side
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] prot,
    input wire logic [7:0] sec,
    input wire logic [7:0] dly,
    // Core side
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic start,
    input wire logic abort,
    output logic done
);
    // ------
    // Core
    // ------
    logic [7:0] cnt;
    // Upper byte inverted so a wrong lane never looks right
    assign rd_data = (rd_addr == 16'hFF0C) ? {~prot, prot} :
        (rd_addr == 16'hFF0E) ? {~sec, sec} : ~rd_addr;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= (cnt == 8'h01);
            cnt <= start ? dly : (abort || cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
        end
    end
endmodule : array_core_model

`default_nettype wire

// >>> sim/flash_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none

`include "flash_cfg.svh"

module flash_checker_properties
    import flash_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Bus
    input wire logic AWVALID,
    input wire logic WVALID,
    input wire logic AWREADY,
    input wire logic ARREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    // System and core
    input wire logic CPU_I_MASK,
    input wire logic CPU_STALL,
    input wire logic IRQ_REQ,
    input wire logic OP_START,
    input wire cmd_s OP_CMD
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    wr_answer_a: assert property (AWVALID && WVALID && AWREADY |=> BVALID)
        else $error("write taken without response");
    resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    one_write_a: assert property (BVALID |-> !AWREADY)
        else $error("write taken with response pending");
    stall_gate_a: assert property (CPU_STALL |-> !AWREADY && !ARREADY)
        else $error("bus taken during boot load");
    boot_stall_a: assert property ($rose(RST_B) |-> CPU_STALL ##1 CPU_STALL ##1 !CPU_STALL)
        else $error("boot stall length wrong");
    irq_mask_a: assert property (CPU_I_MASK |=> !IRQ_REQ)
        else $error("interrupt not masked");
    start_pulse_a: assert property (OP_START |=> !OP_START)
        else $error("start longer than one cycle");
    sector_cmd_a: assert property (OP_START && OP_CMD.code == `CMD_SECTOR_ERASE |->
        OP_CMD.addr[9:0] == 10'h000 && OP_CMD.data == 16'h0000)
        else $error("sector erase address not aligned");
endmodule : flash_checker_properties

bind flash_command_error_checker flash_checker_properties i_flash_checker_properties (
    .CLK, .RST_B, .AWVALID, .WVALID, .AWREADY, .ARREADY, .BRESP, .BVALID, .BREADY,
    .CPU_I_MASK, .CPU_STALL, .IRQ_REQ, .OP_START, .OP_CMD);

`default_nettype wire

// >>> sim/test_flash_command_error_checker.sv
`timescale 1ns/1ps
`default_nettype none

module test_flash_command_error_checker
    import flash_pkg::*;
;
    logic CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, STOP_REQ, BDM_ACTIVE;
    logic CPU_I_MASK, AWREADY, WREADY, BVALID, ARREADY, RVALID, CPU_STALL, IRQ_REQ;
    logic OP_START, OP_ABORT, OP_DONE;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA, v;
    logic [3:0] WSTRB;
    logic [2:0] AWPROT;
    logic [1:0] BRESP, RRESP;
    logic [15:0] ARR_RD_ADDR, ARR_RD_DATA;
    logic [6:0] OP_CLK_DIV;
    logic [7:0] prot_v, sec_v, dly_v;
    cmd_s OP_CMD;
    int n_errors, n_tests, n_starts, n_aborts, cyc;

    flash_command_error_checker i_flash_command_error_checker (
        .CLK, .RST_B, .AWADDR, .AWPROT, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
        .BRESP, .BVALID, .BREADY, .ARADDR, .ARPROT(3'h0), .ARVALID, .ARREADY, .RDATA, .RRESP,
        .RVALID, .RREADY, .STOP_REQ, .BDM_ACTIVE, .CPU_I_MASK, .CPU_STALL, .IRQ_REQ,
        .ARR_RD_ADDR, .ARR_RD_DATA, .OP_START, .OP_CMD, .OP_ABORT, .OP_CLK_DIV, .OP_DONE);
    array_core_model i_array_core_model (.clk(CLK), .rst_b(RST_B), .prot(prot_v),
        .sec(sec_v), .dly(dly_v), .rd_addr(ARR_RD_ADDR), .rd_data(ARR_RD_DATA),
        .start(OP_START), .abort(OP_ABORT), .done(OP_DONE));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cyc++;
        if (OP_START === 1'b1) n_starts++;
        if (OP_ABORT === 1'b1) n_aborts++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ------
    // Tasks
    // ------
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'h3);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do @(posedge CLK); while (AWREADY !== 1'b1);
        AWVALID <= 1'b0;
        WVALID <= 1'b0;
        while (BVALID !== 1'b1) @(posedge CLK);
        BREADY <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        while (RVALID !== 1'b1) @(posedge CLK);
        v = RDATA;
        RREADY <= 1'b0;
    endtask : rd

    task automatic st(input logic [3:0] m, input logic [3:0] e);
        rd(32'h10);
        chk(v[7:4] & m, e);
    endtask : st

    task automatic erase(input logic [31:0] a, input logic [31:0] c = 32'h40);
        wr(a, 0);
        wr(32'h14, c);
        wr(32'h10, 32'h80);
    endtask : erase

    task automatic reset_dut();
        RST_B <= 1'b0;
        repeat (5) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge CLK);
    endtask : reset_dut

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ----------
    // Scenarios
    // ----------
    task automatic t_boot();
        rd(32'h8);
        chk(v, 32'h01);
        rd(32'hC);
        chk(v, 32'hFE);
        wr(32'h10000, 0);
        st(4'hF, 4'hD);
        wr(32'h10, 32'hB0);
        st(4'hF, 4'hC);
        wr(32'h0, 32'h05);
        chk(OP_CLK_DIV, 7'h05);
        $display("boot test done");
    endtask : t_boot

    task automatic t_erase();
        int n0;
        n0 = n_starts;
        wr(32'h11404, 32'h1234);
        st(4'hF, 4'hC);
        wr(32'h14, 32'h40);
        wr(32'h10, 32'h80);
        for (int i = 0; i < 9 && OP_START !== 1'b1; i++) @(posedge CLK);
        chk(OP_CMD, {8'h40, 16'h1400, 16'h0000});
        rd(32'h10000);
        chk(v, 32'hFFFFFFFF);
        st(4'h5, 4'h0);
        while (OP_DONE !== 1'b1) @(posedge CLK);
        repeat (2) @(posedge CLK);
        st(4'hF, 4'hC);
        chk(n_starts - n0, 1);
        $display("erase test done");
    endtask : t_erase

    task automatic t_access();
        int n0;
        for (int k = 0; k < 8; k++) begin
            if (k > 1) wr(32'h11404, 0);
            if (k > 3) wr(32'h14, k == 5 ? 32'h33 : 32'h40);
            case (k)
                0: wr(32'h11405, 0);
                1: wr(32'h11404, 0, 4'h1);
                2: wr(32'h11406, 0, 4'hC);
                3: wr(32'h4, 0);
                4: wr(32'h14, 32'h40);
                6: wr(32'h4, 0);
                7: wr(32'h10, 0);
                default: ;
            endcase
            st(4'hF, 4'hD);
            wr(32'h10, 32'hB0);
        end
        n0 = n_starts;
        wr(32'h11405, 0);
        erase(32'h11404);
        repeat (5) @(posedge CLK);
        chk(n_starts - n0, 0);
        // Zero in the error bit must leave it set; launch still refused
        wr(32'h10, 32'h80);
        st(4'h1, 4'h1);
        wr(32'h10, 0);
        wr(32'h10, 32'hB0);
        st(4'hF, 4'hC);
        $display("access test done");
    endtask : t_access

    task automatic t_protect();
        int n0;
        n0 = n_starts;
        erase(32'h10000);
        st(4'hF, 4'hE);
        chk(n_starts - n0, 0);
        wr(32'h10, 32'hB0);
        st(4'hF, 4'hC);
        wr(32'h11404, 0);
        wr(32'h14, 32'h41);
        st(4'hF, 4'hE);
        wr(32'h10, 32'hB0);
        $display("protect test done");
    endtask : t_protect

    task automatic t_stop();
        int n0;
        n0 = n_aborts;
        erase(32'h11404);
        repeat (6) @(posedge CLK);
        STOP_REQ <= 1'b1;
        repeat (3) @(posedge CLK);
        STOP_REQ <= 1'b0;
        chk(n_aborts - n0, 1);
        st(4'h1, 4'h1);
        wr(32'h10, 32'hB0);
        erase(32'h11404);
        repeat (4) @(posedge CLK);
        reset_dut();
        st(4'hF, 4'hC);
        wr(32'h0, 32'h05);
        $display("stop test done");
    endtask : t_stop

    task automatic t_irq();
        for (int k = 0; k < 4; k++) begin
            wr(32'h4, k == 2 ? 32'h40 : k == 3 ? 32'h00 : 32'h80);
            CPU_I_MASK <= (k == 1);
            repeat (3) @(posedge CLK);
            chk(IRQ_REQ, k == 0 || k == 2);
        end
        $display("irq test done");
    endtask : t_irq

    task automatic t_sec();
        prot_v <= 8'h00;
        sec_v <= 8'h00;
        reset_dut();
        wr(32'h0, 32'h05);
        for (int k = 0; k < 3; k++) begin
            wr(32'h11404, 0);
            AWPROT <= (k == 1) ? 3'h0 : 3'h2;
            BDM_ACTIVE <= (k == 1);
            wr(32'h14, k == 2 ? 32'h41 : 32'h40);
            AWPROT <= 3'h0;
            BDM_ACTIVE <= 1'b0;
            st(4'h1, k == 2 ? 4'h0 : 4'h1);
            if (k < 2) wr(32'h10, 32'hB0);
        end
        $display("security test done");
    endtask : t_sec

    initial begin
        {RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, STOP_REQ, BDM_ACTIVE} = '0;
        {AWADDR, WDATA, ARADDR, WSTRB, AWPROT} = '0;
        CPU_I_MASK = 1'b1;
        prot_v = 8'h01;
        sec_v = 8'hFE;
        dly_v = 8'h30;
        reset_dut();
        t_boot();
        t_erase();
        t_access();
        t_protect();
        t_stop();
        t_irq();
        t_sec();
        tally_and_finish();
    end
endmodule : test_flash_command_error_checker

`default_nettype wire
